// ### verilog/mic_pga_regs.svh
// register offsets, field positions and reset values for the mic and pga control bank
`ifndef MIC_PGA_REGS_SVH
`define MIC_PGA_REGS_SVH
`define IDX_PLL_FRAC_HIGH 8'h25
`define IDX_PLL_FRAC_MID 8'h26
`define IDX_PLL_FRAC_LOW 8'h27
`define IDX_RSVD_A 8'h28
`define IDX_RSVD_B 8'h29
`define IDX_LEVEL_LOOP_ZC 8'h2a
`define IDX_RSVD_C 8'h2b
`define IDX_INPUT_ROUTING 8'h2c
`define IDX_AMP_GAIN 8'h2d
`define IDX_RSVD_D 8'h2e
`define RST_PLL_FRAC_HIGH 6'h0c
`define RST_PLL_FRAC_MID 9'h093
`define RST_PLL_FRAC_LOW 9'h0e9
`define RST_LEVEL_LOOP_ZC 1'h0
`define RST_MIC_BIAS 1'h0
`define RST_AUX_CONFIG 1'h0
`define RST_AUX_TO_NEG 1'h0
`define RST_MIC_NEG_TO_NEG 1'h1
`define RST_MIC_POS_TO_POS 1'h0
`define RST_AMP_ZC 1'h0
`define RST_AMP_MUTE 1'h1
`define RST_AMP_VOLUME 6'h10
`define BIT_LEVEL_LOOP_ZC 1
`define BIT_MIC_BIAS 8
`define BIT_AUX_CONFIG 3
`define BIT_AUX_TO_NEG 2
`define BIT_MIC_NEG_TO_NEG 1
`define BIT_MIC_POS_TO_POS 0
`define BIT_AMP_ZC 7
`define BIT_AMP_MUTE 6
`define BIT_AMP_VOL_MSB 5
`define BIT_AMP_VOL_LSB 0
`endif

// ### verilog/mic_pga_pkg.sv
// types for the mic and pga control bank
package mic_pga_pkg;
  typedef struct packed {
    logic mic_bias_level_select;
    logic aux_input_config;
    logic aux_to_amp_negative;
    logic mic_neg_to_amp_negative;
    logic mic_pos_to_amp_positive;
  } routing_t;
  typedef struct packed {
    logic amp_gain_zc_update;
    logic amp_mute;
    logic [5:0] amp_volume_code;
  } amp_ctrl_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ACK = 3'b010,
    ST_DONE = 3'b100
  } bus_state_t;
endpackage

// ### verilog/mic_pga_pll_control_regs.sv
// avalon-mm register bank for pll fraction, level loop zero cross, input routing and pga
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ps
`include "mic_pga_regs.svh"
module mic_pga_pll_control_regs (
  input wire logic ref_clk, // 10 mhz register clock
  input wire logic reset_n, // async reset, active low
  input wire logic [9:0] avs_address, // byte address, word aligned
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte enables
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall, low on answer edge
  output logic [23:0] pll_fraction_ratio, // full fractional ratio
  output logic level_loop_zc_enable, // level loop waits for zero cross
  output mic_pga_pkg::routing_t routing, // input routing and bias
  output mic_pga_pkg::amp_ctrl_t amp_ctrl // pga controls
);
  logic [5:0] frac_high_q;
  logic [8:0] frac_mid_q;
  logic [8:0] frac_low_q;
  logic level_zc_q;
  mic_pga_pkg::routing_t routing_q;
  mic_pga_pkg::amp_ctrl_t amp_q;
  mic_pga_pkg::bus_state_t state_q;
  logic [7:0] idx;
  logic wr_take;
  logic [15:0] rd_d;

  // word index from byte address
  assign idx = avs_address[9:2];
  // write lands on the single answer edge only
  assign wr_take = avs_write && (state_q == mic_pga_pkg::ST_ACK);

  // merge byte enables into a 16-bit register image
  function automatic logic [15:0] merge(input logic [15:0] old_v, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [15:0] r;
    r = old_v;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // bus handshake: idle, one wait cycle, answer with waitrequest low, then release
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= mic_pga_pkg::ST_IDLE;
    end else begin
      case (state_q)
        mic_pga_pkg::ST_IDLE: begin
          if (avs_read || avs_write) begin
            state_q <= mic_pga_pkg::ST_ACK;
          end
        end
        mic_pga_pkg::ST_ACK: begin
          state_q <= mic_pga_pkg::ST_DONE;
        end
        mic_pga_pkg::ST_DONE: begin
          state_q <= mic_pga_pkg::ST_IDLE;
        end
        default: begin
          state_q <= mic_pga_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // waitrequest is registered, so it drops exactly during the answer cycle
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((state_q == mic_pga_pkg::ST_IDLE) && (avs_read || avs_write));
    end
  end

  // pll fraction registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      frac_high_q <= `RST_PLL_FRAC_HIGH;
      frac_mid_q <= `RST_PLL_FRAC_MID;
      frac_low_q <= `RST_PLL_FRAC_LOW;
    end else if (wr_take) begin
      if (idx == `IDX_PLL_FRAC_HIGH) begin
        frac_high_q <= 6'(merge({10'h000, frac_high_q}, avs_writedata,
                                avs_byteenable));
      end
      if (idx == `IDX_PLL_FRAC_MID) begin
        frac_mid_q <= 9'(merge({7'h00, frac_mid_q}, avs_writedata,
                               avs_byteenable));
      end
      if (idx == `IDX_PLL_FRAC_LOW) begin
        frac_low_q <= 9'(merge({7'h00, frac_low_q}, avs_writedata,
                               avs_byteenable));
      end
    end
  end

  // level loop zero cross select; bit 0 of its word is reserved and dropped
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      level_zc_q <= `RST_LEVEL_LOOP_ZC;
    end else if (wr_take && idx == `IDX_LEVEL_LOOP_ZC && avs_byteenable[0]) begin
      level_zc_q <= avs_writedata[`BIT_LEVEL_LOOP_ZC];
    end
  end

  // routing and bias; bits 7:4 are reserved, so only named bits are stored
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      routing_q.mic_bias_level_select <= `RST_MIC_BIAS;
      routing_q.aux_input_config <= `RST_AUX_CONFIG;
      routing_q.aux_to_amp_negative <= `RST_AUX_TO_NEG;
      routing_q.mic_neg_to_amp_negative <= `RST_MIC_NEG_TO_NEG;
      routing_q.mic_pos_to_amp_positive <= `RST_MIC_POS_TO_POS;
    end else if (wr_take && idx == `IDX_INPUT_ROUTING) begin
      if (avs_byteenable[1]) begin
        routing_q.mic_bias_level_select <= avs_writedata[`BIT_MIC_BIAS];
      end
      if (avs_byteenable[0]) begin
        routing_q.aux_input_config <= avs_writedata[`BIT_AUX_CONFIG];
        routing_q.aux_to_amp_negative <= avs_writedata[`BIT_AUX_TO_NEG];
        routing_q.mic_neg_to_amp_negative <= avs_writedata[`BIT_MIC_NEG_TO_NEG];
        routing_q.mic_pos_to_amp_positive <= avs_writedata[`BIT_MIC_POS_TO_POS];
      end
    end
  end

  // pga control; zero cross timing itself lives in the analog path
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      amp_q.amp_gain_zc_update <= `RST_AMP_ZC;
      amp_q.amp_mute <= `RST_AMP_MUTE;
      amp_q.amp_volume_code <= `RST_AMP_VOLUME;
    end else if (wr_take && idx == `IDX_AMP_GAIN && avs_byteenable[0]) begin
      amp_q.amp_gain_zc_update <= avs_writedata[`BIT_AMP_ZC];
      amp_q.amp_mute <= avs_writedata[`BIT_AMP_MUTE];
      amp_q.amp_volume_code <= avs_writedata[`BIT_AMP_VOL_MSB:`BIT_AMP_VOL_LSB];
    end
  end

  // readback mux; reserved and unmapped words read zero
  always_comb begin
    rd_d = 16'h0000;
    case (idx)
      `IDX_PLL_FRAC_HIGH: rd_d = {10'h000, frac_high_q};
      `IDX_PLL_FRAC_MID: rd_d = {7'h00, frac_mid_q};
      `IDX_PLL_FRAC_LOW: rd_d = {7'h00, frac_low_q};
      `IDX_LEVEL_LOOP_ZC: rd_d = {14'h0000, level_zc_q, 1'b0};
      `IDX_INPUT_ROUTING: rd_d = {7'h00, routing_q.mic_bias_level_select, 4'h0,
                                  routing_q.aux_input_config, routing_q.aux_to_amp_negative,
                                  routing_q.mic_neg_to_amp_negative,
                                  routing_q.mic_pos_to_amp_positive};
      `IDX_AMP_GAIN: rd_d = {8'h00, amp_q};
      default: rd_d = 16'h0000;
    endcase
  end

  // read data registered so it stands with waitrequest low
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (state_q == mic_pga_pkg::ST_IDLE && avs_read) begin
      avs_readdata <= {16'h0000, rd_d};
    end
  end

  // analog and pll control outputs, registered copies of the fields
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pll_fraction_ratio <= {`RST_PLL_FRAC_HIGH, `RST_PLL_FRAC_MID, `RST_PLL_FRAC_LOW};
      level_loop_zc_enable <= `RST_LEVEL_LOOP_ZC;
      // outputs carry the field defaults, so the amp is muted while reset is held
      routing <= {`RST_MIC_BIAS, `RST_AUX_CONFIG, `RST_AUX_TO_NEG, `RST_MIC_NEG_TO_NEG,
                  `RST_MIC_POS_TO_POS};
      amp_ctrl <= {`RST_AMP_ZC, `RST_AMP_MUTE, `RST_AMP_VOLUME};
    end else begin
      pll_fraction_ratio <= {frac_high_q, frac_mid_q, frac_low_q};
      level_loop_zc_enable <= level_zc_q;
      routing <= routing_q;
      amp_ctrl <= amp_q;
    end
  end

  // after reset the amp is muted and mic negative is routed, fields and outputs alike
  a_reset_defaults: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(reset_n) |-> amp_q.amp_mute && routing_q.mic_neg_to_amp_negative &&
    amp_ctrl.amp_mute && routing.mic_neg_to_amp_negative)
    else $error("reset defaults wrong");

  a_reset_outputs: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(reset_n) |-> pll_fraction_ratio == {`RST_PLL_FRAC_HIGH, `RST_PLL_FRAC_MID,
    `RST_PLL_FRAC_LOW} && amp_ctrl.amp_volume_code == `RST_AMP_VOLUME)
    else $error("reset outputs wrong");

  // each written field shows on its output one cycle after the answer edge
  a_vol_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (wr_take && idx == `IDX_AMP_GAIN && avs_byteenable[0]) |=> ##1
    amp_ctrl.amp_volume_code == $past(avs_writedata[5:0], 2))
    else $error("volume write not reflected");

  a_mute_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (wr_take && idx == `IDX_AMP_GAIN && avs_byteenable[0]) |=> ##1
    amp_ctrl.amp_mute == $past(avs_writedata[`BIT_AMP_MUTE], 2))
    else $error("mute write not reflected");

  a_amp_zc_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (wr_take && idx == `IDX_AMP_GAIN && avs_byteenable[0]) |=> ##1
    amp_ctrl.amp_gain_zc_update == $past(avs_writedata[`BIT_AMP_ZC], 2))
    else $error("gain timing write not reflected");

  a_aux_mode_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (wr_take && idx == `IDX_INPUT_ROUTING && avs_byteenable[0]) |=> ##1
    routing.aux_input_config == $past(avs_writedata[`BIT_AUX_CONFIG], 2))
    else $error("aux mode write not reflected");

  a_aux_neg_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (wr_take && idx == `IDX_INPUT_ROUTING && avs_byteenable[0]) |=> ##1
    routing.aux_to_amp_negative == $past(avs_writedata[`BIT_AUX_TO_NEG], 2))
    else $error("aux switch write not reflected");

  a_mic_negative_pin_neg_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (wr_take && idx == `IDX_INPUT_ROUTING && avs_byteenable[0]) |=> ##1
    routing.mic_neg_to_amp_negative == $past(avs_writedata[`BIT_MIC_NEG_TO_NEG], 2))
    else $error("mic negative write not reflected");

  a_mic_positive_pin_pos_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (wr_take && idx == `IDX_INPUT_ROUTING && avs_byteenable[0]) |=> ##1
    routing.mic_pos_to_amp_positive == $past(avs_writedata[`BIT_MIC_POS_TO_POS], 2))
    else $error("mic positive write not reflected");

  a_bias_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (wr_take && idx == `IDX_INPUT_ROUTING && avs_byteenable[1]) |=> ##1
    routing.mic_bias_level_select == $past(avs_writedata[8], 2))
    else $error("bias select not followed");

  a_zc_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (wr_take && idx == `IDX_LEVEL_LOOP_ZC && avs_byteenable[0]) |=> ##1
    level_loop_zc_enable == $past(avs_writedata[1], 2))
    else $error("level zero cross not followed");

  a_frac_follow: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (wr_take && idx == `IDX_PLL_FRAC_LOW && avs_byteenable == 4'hf) |=> ##1
    pll_fraction_ratio[8:0] == $past(avs_writedata[8:0], 2))
    else $error("fraction low not followed");

  a_frac_mid_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (wr_take && idx == `IDX_PLL_FRAC_MID && avs_byteenable == 4'hf) |=> ##1
    pll_fraction_ratio[17:9] == $past(avs_writedata[8:0], 2))
    else $error("fraction mid not followed");

  a_frac_high_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (wr_take && idx == `IDX_PLL_FRAC_HIGH && avs_byteenable[0]) |=> ##1
    pll_fraction_ratio[23:18] == $past(avs_writedata[5:0], 2))
    else $error("fraction high not followed");

  // reserved words and bits read zero and swallow writes
  a_rsvd_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_q == mic_pga_pkg::ST_IDLE && avs_read && (idx == `IDX_RSVD_A ||
    idx == `IDX_RSVD_B || idx == `IDX_RSVD_C || idx == `IDX_RSVD_D)) |=>
    avs_readdata == 32'h0000_0000)
    else $error("reserved word not zero");

  a_rsvd_write_ignored: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (wr_take && (idx == `IDX_RSVD_A || idx == `IDX_RSVD_B || idx == `IDX_RSVD_C ||
    idx == `IDX_RSVD_D)) |=> ##1 $stable(pll_fraction_ratio) && $stable(routing) &&
    $stable(amp_ctrl) && $stable(level_loop_zc_enable))
    else $error("reserved write changed an output");

  a_upper_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !avs_waitrequest |-> avs_readdata[31:9] == 23'h000000)
    else $error("reserved bits nonzero");

  a_level_rsvd_read: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_q == mic_pga_pkg::ST_IDLE && avs_read && idx == `IDX_LEVEL_LOOP_ZC) |=>
    avs_readdata[15:2] == 14'h0000 && !avs_readdata[0])
    else $error("level word reserved bits nonzero");

  a_route_rsvd_read: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_q == mic_pga_pkg::ST_IDLE && avs_read && idx == `IDX_INPUT_ROUTING) |=>
    avs_readdata[15:9] == 7'h00 && avs_readdata[7:4] == 4'h0)
    else $error("routing word reserved bits nonzero");

  // every access, reserved ones too, is answered after one wait cycle
  a_ack_bound: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_q == mic_pga_pkg::ST_IDLE && (avs_read || avs_write)) |=> !avs_waitrequest ##1
    avs_waitrequest)
    else $error("answer timing wrong");
endmodule

// ### sim/host_master.sv
// host processor model: avalon-mm master driving the control bank
`timescale 1ns/1ps
module host_master (
  input wire logic ref_clk, // register clock
  output logic [9:0] avs_address, // byte address
  output logic avs_read, // read request
  output logic avs_write, // write request
  output logic [31:0] avs_writedata, // write data
  output logic [3:0] avs_byteenable, // byte enables
  input wire logic [31:0] avs_readdata, // read data
  input wire logic avs_waitrequest // stall
);
  int hangs = 0;
  // idle bus at time zero
  initial begin
    avs_address = 10'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h0;
  end
  // one access, entered just after a rising edge; held until waitrequest is seen low or 20 rising edges pass
  task automatic access(input logic wr, input logic [7:0] idx, input logic [15:0] wd,
                        input logic [3:0] be, output logic [31:0] rd);
    int n;
    n = 0;
    // a write to the integer ratio word keeps that field inside its legal span
    if (wr && idx == 8'h24 && (wd[3:0] < 4'h6 || wd[3:0] > 4'hc)) wd[3:0] = 4'h8;
    avs_address <= {idx, 2'b00};
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= {16'h0000, wd};
    avs_byteenable <= be;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) hangs++;
    rd = avs_readdata;
    // released address and data lines show inverted garbage, not the last value
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_address <= ~{idx, 2'b00};
    avs_writedata <= ~{16'h0000, wd};
    // bank spends one cycle in done before the next request
    @(posedge ref_clk);
  endtask
endmodule

// ### sim/mic_pga_pll_control_regs_tb.sv
// self-checking bench for the mic pga and pll control bank
`timescale 1ns/1ps
module mic_pga_pll_control_regs_tb;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [9:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [23:0] pll_fraction_ratio;
  logic level_loop_zc_enable;
  mic_pga_pkg::routing_t routing;
  mic_pga_pkg::amp_ctrl_t amp_ctrl;
  int miscompares = 0;
  int num_checks = 0;
  int regs[256];
  int masks[256];
  logic [31:0] rd;
  always #50 ref_clk = ~ref_clk;
  mic_pga_pll_control_regs u_dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pll_fraction_ratio(pll_fraction_ratio), .level_loop_zc_enable(level_loop_zc_enable),
    .routing(routing), .amp_ctrl(amp_ctrl));
  host_master u_host (.ref_clk(ref_clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    miscompares += u_host.hangs;
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // reference values after reset; unlisted places stay zero
  task automatic model_reset();
    foreach (regs[i]) regs[i] = 0;
    regs[8'h25] = 32'h0000_000c;
    regs[8'h26] = 32'h0000_0093;
    regs[8'h27] = 32'h0000_00e9;
    regs[8'h2c] = 32'h0000_0002;
    regs[8'h2d] = 32'h0000_0050;
  endtask
  // one bus cycle; the model follows only lanes enabled and bits that exist
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [15:0] wd,
                     input logic [3:0] be);
    int lanes;
    u_host.access(wr, idx, wd, be, rd);
    if (u_host.hangs != 0) wrap_up();
    lanes = (be[0] ? 16'h00ff : 16'h0000) | (be[1] ? 16'hff00 : 16'h0000);
    if (wr) regs[idx] = (regs[idx] & ~(lanes & masks[idx])) | (wd & lanes & masks[idx]);
  endtask
  // compare control outputs once settled, then read back every place
  task automatic check_all();
    logic [15:0] r2c;
    logic [23:0] frac;
    r2c = regs[8'h2c][15:0];
    frac = {regs[8'h25][5:0], regs[8'h26][8:0], regs[8'h27][8:0]};
    @(negedge ref_clk);
    chk({8'h00, pll_fraction_ratio}, {8'h00, frac});
    chk({31'h0, level_loop_zc_enable}, {31'h0, regs[8'h2a][1]});
    chk({27'h0, routing}, {27'h0, r2c[8], r2c[3:0]});
    chk({24'h0, amp_ctrl}, {24'h0, regs[8'h2d][7:0]});
    @(posedge ref_clk);
    for (int i = 8'h20; i < 8'h30; i++) begin
      bus(1'b0, i[7:0], 16'h0000, 4'hf);
      chk(rd, {16'h0000, regs[i][15:0]});
    end
  endtask
  initial begin
    masks[8'h25] = 16'h003f;
    masks[8'h26] = 16'h01ff;
    masks[8'h27] = 16'h01ff;
    masks[8'h2a] = 16'h0002;
    masks[8'h2c] = 16'h010f;
    masks[8'h2d] = 16'h00ff;
    void'($urandom(66343));
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    model_reset();
    @(posedge ref_clk);
    check_all();
    // all ones then all zeros everywhere, reserved and unmapped included
    for (int i = 8'h20; i < 8'h30; i++) bus(1'b1, i[7:0], 16'hffff, 4'hf);
    check_all();
    for (int i = 8'h20; i < 8'h30; i++) bus(1'b1, i[7:0], 16'h0000, 4'hf);
    check_all();
    // random writes with random byte lanes, back to back with readback
    for (int k = 0; k < 60; k++) begin
      bus(1'b1, 8'h22 + 8'($urandom_range(13)), 16'($urandom), 4'($urandom));
      check_all();
    end
    // second reset in mid-run must restore every default
    reset_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    model_reset();
    @(posedge ref_clk);
    check_all();
    wrap_up();
  end
endmodule
